// ### src/cell_storage_consts.vh
// Behaviour
// - elements act as latch or flip-flop, either polarity
// - latch or flip-flop chosen per element
// - one shared clock, one cell-wide clock invert
// - cell-wide pick of table bit or direct bit
// - missing pad path gives constant zero, default
// - edge columns offer side pad inputs, edge rows vertical pad inputs
// - any element output onto any cell output
// - inactive clock enable holds flip-flop at edge
// - clock enable gates flip-flops only, never latches
// - clock enable and set/reset may be inverted
// - local set/reset synchronous or asynchronous, cell-wide
// - synchronous set/reset needs active clock enable on flip-flops only
// - priority option lets set/reset override enable
// - no set/reset asserted: normal latch or flip-flop
// - global init low forces every element, asynchronously
// - per-element bit picks set or reset value
// - front-end mode: set/reset line selects data source
`ifndef CELL_STORAGE_CONSTS_VH
`define CELL_STORAGE_CONSTS_VH

// bus geometry
`define BUS_W          32
`define ADDR_W         4
`define BE_W           4
`define BYTE_W         8

// register byte addresses
`define CELL_CTRL_ADDR 4'h0
`define ELEM_CTRL_ADDR 4'h4
`define OUT_SEL_ADDR   4'h8
`define STATUS_ADDR    4'hC

// register widths and reset values
`define CC_W           7
`define EC_W           16
`define OS_W           10
`define CELL_CTRL_RST  7'h00
`define ELEM_CTRL_RST  16'h5500
`define OUT_SEL_RST    10'h0E4

// cell control fields
`define CC_CLK_INV     0
`define CC_FE_DIRECT   1
`define CC_CE_INV      2
`define CC_SR_INV      3
`define CC_MODE_LO     4
`define CC_MODE_HI     5
`define CC_PRIO        6

// set/reset modes
`define MODE_SYNC      2'h0
`define MODE_ASYNC     2'h1
`define MODE_FES       2'h2

// element control fields
`define EC_FF_LO       0
`define EC_SET_LO      4
`define EC_SRC_LO      8
`define SRC_W          2

// per-element data sources
`define SRC_FRONT      2'h0
`define SRC_ZERO       2'h1
`define SRC_SIDE       2'h2
`define SRC_VERT       2'h3

// element and output counts
`define ELEM_N         4
`define OUT_N          5
`define OSEL_W         2
`define SYNC_W         20
`define EDGE_RINGS     2

// status fields
`define ST_Q_LO        0
`define ST_SIDE_OK     4
`define ST_VERT_OK     5
`define ST_CLK_LVL     6

`endif

// ### src/cell_storage_elements.v
`timescale 1ns/1ps
`default_nettype none
`include "cell_storage_consts.vh"

// four storage elements of one logic cell, options set over the bus
module cell_storage_elements #(
  parameter integer ARRAY_COLS = 10,      // columns of cells in the array
  parameter integer ARRAY_ROWS = 10,      // rows of cells in the array
  parameter integer CELL_COL   = 0,       // column of this cell
  parameter integer CELL_ROW   = 0        // row of this cell
) (
  input  wire                 clk,
  input  wire                 rstn,
  input  wire [`ADDR_W-1:0]   avs_address,
  input  wire                 avs_read,
  input  wire                 avs_write,
  input  wire [`BUS_W-1:0]    avs_writedata,
  input  wire [`BE_W-1:0]     avs_byteenable,
  output reg  [`BUS_W-1:0]    avs_readdata,
  output reg                  avs_waitrequest,
  input  wire [`ELEM_N-1:0]   quarter_table,
  input  wire [`ELEM_N-1:0]   direct_data_in,
  input  wire [`ELEM_N-1:0]   side_pad_in,
  input  wire [`ELEM_N-1:0]   vert_pad_in,
  input  wire                 cell_clock,
  input  wire                 clock_enable,
  input  wire                 local_set_reset,
  input  wire                 global_init_low,
  output reg  [`ELEM_N-1:0]   storage_q,
  output reg  [`OUT_N-1:0]    cell_out
);

  // configuration registers
  // all three are written only by the bus process
  reg  [`CC_W-1:0]    cell_ctrl_reg;      // cell-wide options
  reg  [`EC_W-1:0]    elem_ctrl_reg;      // per-element options
  reg  [`OS_W-1:0]    out_sel_reg;        // output routing

  // two-stage synchronisers for all fabric inputs
  reg  [`SYNC_W-1:0]  sync1_reg;          // first stage, read only by second
  reg  [`SYNC_W-1:0]  sync2_reg;          // second stage, safe to use
  reg                 clk_lvl_prev_reg;   // last effective cell clock level

  // synchronised views
  // split back out of the second synchroniser stage
  wire [`ELEM_N-1:0]  tbl_s;
  wire [`ELEM_N-1:0]  dir_s;
  wire [`ELEM_N-1:0]  side_s;
  wire [`ELEM_N-1:0]  vert_s;
  wire                cclk_s;
  wire                ce_s;
  wire                sr_s;
  wire                ginit_s;

  // decoded control
  // derived every cycle from synchronised inputs and config
  wire                clk_lvl;            // effective clock level
  wire                clk_edge;           // effective rising edge
  wire                ce_act;             // clock enable, polarity applied
  wire                sr_act;             // local set/reset, polarity applied
  wire                glob_act;           // global init asserted
  wire [1:0]          sr_mode;            // sync, async or front-end select
  wire                prio;               // set/reset beats clock enable
  wire                fe_direct;          // front end takes direct bits
  wire                side_ok;            // side pad path exists here
  wire                vert_ok;            // vertical pad path exists here
  wire [`ELEM_N-1:0]  q_next;             // per-element next state
  reg  [`OUT_N-1:0]   out_next;           // routed outputs
  reg  [`BUS_W-1:0]   rd_word;            // read mux
  wire [`BUS_W-1:0]   be_mask;            // byte enable mask
  // merged write words, cut to register width on the write
  wire [`BUS_W-1:0]   cc_merged;          // cell control after lane merge
  wire [`BUS_W-1:0]   ec_merged;          // element control after lane merge
  wire [`BUS_W-1:0]   os_merged;          // output select after lane merge

  assign {ginit_s, sr_s, ce_s, cclk_s, vert_s, side_s, dir_s, tbl_s} = sync2_reg;

  // every input crosses two flops; the cell clock is only ever sampled
  // the cell clock is treated as data: each of its phases
  // must last at least one system clock or an edge is lost
  // resetting to zero makes global init look asserted briefly
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= {`SYNC_W{1'b0}};
      sync2_reg <= {`SYNC_W{1'b0}};
    end else begin
      // all fabric inputs share one synchroniser word
      sync1_reg <= {global_init_low, local_set_reset, clock_enable, cell_clock,
                    vert_pad_in, side_pad_in, direct_data_in, quarter_table};
      sync2_reg <= sync1_reg;
    end
  end

  // shared clock with one cell-wide invert
  assign clk_lvl = cclk_s ^ cell_ctrl_reg[`CC_CLK_INV];
  assign clk_edge = clk_lvl & ~clk_lvl_prev_reg;

  // previous level for edge detection
  // reset level zero matches the idle cell clock with invert off,
  // so the release of reset gives no false edge
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clk_lvl_prev_reg <= 1'b0;
    end else begin
      clk_lvl_prev_reg <= clk_lvl;
    end
  end

  // polarity of enable and set/reset
  // each inversion is a plain xor; the raw synchronised
  // level is never used past this point
  assign ce_act = ce_s ^ cell_ctrl_reg[`CC_CE_INV];
  assign sr_act = sr_s ^ cell_ctrl_reg[`CC_SR_INV];
  assign glob_act = ~ginit_s;
  assign sr_mode = cell_ctrl_reg[`CC_MODE_HI:`CC_MODE_LO];
  assign prio = cell_ctrl_reg[`CC_PRIO];

  // front-end select: set/reset line steers data, else the static option
  // in that mode the set/reset line never forces a value;
  // it only steers table or direct bits
  assign fe_direct = (sr_mode == `MODE_FES) ? sr_act
                                            : cell_ctrl_reg[`CC_FE_DIRECT];

  // pad paths exist only in the outer two rings
  // corner cells sit in both rings and get both paths;
  // interior cells read zero from either pad source
  assign side_ok = (CELL_COL < `EDGE_RINGS) ||
                   (CELL_COL >= ARRAY_COLS - `EDGE_RINGS);
  assign vert_ok = (CELL_ROW < `EDGE_RINGS) ||
                   (CELL_ROW >= ARRAY_ROWS - `EDGE_RINGS);

  // one slice per storage element
  // each slice holds its select, its storage rule and its next state
  genvar i;
  generate
    for (i = 0; i < `ELEM_N; i = i + 1) begin : elem
      wire [`SRC_W-1:0] src;              // data source of this element
      wire              is_ff;            // flip-flop, else latch
      wire              set_val;          // value forced by set/reset
      reg               d;                // selected data
      reg               qn;               // next state

      // fields of this element in the element control word
      assign src = elem_ctrl_reg[`EC_SRC_LO + `SRC_W*i +: `SRC_W];
      assign is_ff = elem_ctrl_reg[`EC_FF_LO + i];
      assign set_val = elem_ctrl_reg[`EC_SET_LO + i];

      // data select; an absent pad path reads as zero
      // the zero source and any unplaced pad route give zero,
      // so nothing floating can leak into an element
      always @* begin
        case (src)
          `SRC_FRONT: d = fe_direct ? dir_s[i] : tbl_s[i];
          `SRC_SIDE:  d = side_ok & side_s[i];
          `SRC_VERT:  d = vert_ok & vert_s[i];
          default:    d = 1'b0;
        endcase
      end

      // storage behaviour, highest priority first
      always @* begin
        // hold is the default: qn starts at the present state
        qn = storage_q[i];
        if (glob_act) begin
          // global init outranks every other control
          qn = set_val;
        end else if (sr_mode == `MODE_ASYNC && sr_act) begin
          // asynchronous local set/reset forces while asserted
          qn = set_val;
        end else if (is_ff) begin
          // flip-flop acts only on an effective rising edge
          if (clk_edge) begin
            // sync set/reset gated by enable unless priority is on
            if (sr_mode == `MODE_SYNC && sr_act && (ce_act || prio)) begin
              qn = set_val;
            end else if (ce_act) begin
              qn = d;
            end
          end
        end else if (clk_lvl) begin
          // latch is transparent while the level holds; enable ignored
          if (sr_mode == `MODE_SYNC && sr_act) begin
            qn = set_val;
          end else begin
            qn = d;
          end
        end
      end

      // collected for the routing mux and the state register
      assign q_next[i] = qn;
    end
  endgenerate

  // element state register; async modes act on the next system edge
  // a limitation: forcing is seen on the third system clock edge,
  // since every control here is a sampled copy of its pin;
  // the trade buys one clock domain and no reset glitches
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      storage_q <= {`ELEM_N{1'b0}};
    end else begin
      storage_q <= q_next;
    end
  end

  // output routing mux
  // routes q_next rather than storage_q so that cell_out
  // changes on the same edge as the state it shows
  integer j;
  always @* begin
    out_next = {`OUT_N{1'b0}};
    for (j = 0; j < `OUT_N; j = j + 1) begin
      out_next[j] = q_next[out_sel_reg[j*`OSEL_W +: `OSEL_W]];
    end
  end

  // registered outputs, aligned with storage_q
  // cell_out stays a flop output, never the mux itself
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cell_out <= {`OUT_N{1'b0}};
    end else begin
      cell_out <= out_next;
    end
  end

  // byte lane mask from enables
  // a lane left disabled keeps its old register bits
  assign be_mask = {{`BYTE_W{avs_byteenable[3]}}, {`BYTE_W{avs_byteenable[2]}},
                    {`BYTE_W{avs_byteenable[1]}}, {`BYTE_W{avs_byteenable[0]}}};

  // read mux; unmapped addresses read zero
  // status is read-only and shows live state; it is
  // captured in the request cycle, not the answer cycle
  always @* begin
    rd_word = {`BUS_W{1'b0}};
    case (avs_address)
      `CELL_CTRL_ADDR: rd_word[`CC_W-1:0] = cell_ctrl_reg;
      `ELEM_CTRL_ADDR: rd_word[`EC_W-1:0] = elem_ctrl_reg;
      `OUT_SEL_ADDR:   rd_word[`OS_W-1:0] = out_sel_reg;
      `STATUS_ADDR: begin
        rd_word[`ST_Q_LO +: `ELEM_N] = storage_q;
        rd_word[`ST_SIDE_OK] = side_ok;
        rd_word[`ST_VERT_OK] = vert_ok;
        rd_word[`ST_CLK_LVL] = clk_lvl;
      end
      default: rd_word = {`BUS_W{1'b0}};
    endcase
  end

  // merge write data under byte enables
  // bits outside the enabled lanes keep their old value
  function [`BUS_W-1:0] merge;
    input [`BUS_W-1:0] old;
    input [`BUS_W-1:0] wd;
    input [`BUS_W-1:0] m;
    begin
      merge = (old & ~m) | (wd & m);
    end
  endfunction

  // full-width merged words; the write keeps only the low bits
  assign cc_merged = merge({{(`BUS_W-`CC_W){1'b0}}, cell_ctrl_reg}, avs_writedata, be_mask);
  assign ec_merged = merge({{(`BUS_W-`EC_W){1'b0}}, elem_ctrl_reg}, avs_writedata, be_mask);
  assign os_merged = merge({{(`BUS_W-`OS_W){1'b0}}, out_sel_reg}, avs_writedata, be_mask);

  // avalon slave: one wait cycle, then answer; write lands on the answer edge
  // waitrequest idles high, so every access stalls one cycle;
  // this costs a cycle per access but keeps readdata registered
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      // bus idles stalled, registers at their reset values
      avs_waitrequest <= 1'b1;
      avs_readdata    <= {`BUS_W{1'b0}};
      cell_ctrl_reg   <= `CELL_CTRL_RST;
      elem_ctrl_reg   <= `ELEM_CTRL_RST;
      out_sel_reg     <= `OUT_SEL_RST;
    end else if (!avs_waitrequest) begin
      // answer cycle: release, apply any write
      // one outstanding request only; the master holds it until here
      avs_waitrequest <= 1'b1;
      if (avs_write) begin
        // only the implemented low bits of each word are stored
        case (avs_address)
          `CELL_CTRL_ADDR: cell_ctrl_reg <= cc_merged[`CC_W-1:0];
          `ELEM_CTRL_ADDR: elem_ctrl_reg <= ec_merged[`EC_W-1:0];
          `OUT_SEL_ADDR:   out_sel_reg   <= os_merged[`OS_W-1:0];
          // status and unmapped addresses ignore writes
          default: ;
        endcase
      end
    end else if (avs_read || avs_write) begin
      // request seen: capture read word, drop waitrequest next cycle
      // readdata then stands until the next request is captured
      avs_waitrequest <= 1'b0;
      avs_readdata    <= avs_read ? rd_word : {`BUS_W{1'b0}};
    end
  end

endmodule
`default_nettype wire

// ### testbench/cell_storage_elements_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "cell_storage_consts.vh"
module cell_storage_elements_bench;
  logic              clk, rstn, avs_read, avs_write, cell_clock, clock_enable, local_set_reset, global_init_low;
  logic [3:0]        avs_address, avs_byteenable, level_in;
  logic [31:0]       avs_writedata, rd;
  wire  [31:0]       avs_readdata;
  wire               avs_waitrequest;
  wire  [3:0]        quarter_table, direct_data_in, side_pad_in, vert_pad_in, storage_q;
  wire  [4:0]        cell_out;
  int                err_count, comparisons;
  // row: ctrl, elem ctrl, level before/after rise, enable, set/reset, state
  logic [43:0] rows [16] = '{
    44'h00_000F_A3_10_F, 44'h02_000F_3C_10_3, 44'h01_000F_69_10_C, 44'h02_550F_FF_10_0,
    44'h02_AA0F_66_10_9, 44'h02_FF0F_33_10_C, 44'h02_000F_55_00_C, 44'h06_000F_55_00_5,
    44'h02_0000_A6_00_6, 44'h02_0003_96_10_5, 44'h02_00AF_FF_11_A, 44'h02_005F_FF_01_A,
    44'h42_005F_FF_01_5, 44'h0A_00AF_FF_10_A, 44'h20_000F_33_11_3, 44'h20_000F_33_10_6};
  cell_storage_elements u_cell_storage_elements (.clk, .rstn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .quarter_table, .direct_data_in,
    .side_pad_in, .vert_pad_in, .cell_clock, .clock_enable, .local_set_reset, .global_init_low,
    .storage_q, .cell_out);
  fabric_model u_fabric_model (.level_in, .quarter_table, .direct_data_in, .side_pad_in, .vert_pad_in);
  // free-running system clock, 50 ns
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check_bus(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_cell(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  // one bus transfer; held until waitrequest is seen low, bounded wait
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 50) begin
      err_count++;
      final_report();
    end
  endtask
  initial begin
    logic [43:0] r;
    {rstn, avs_read, avs_write, cell_clock, local_set_reset} = '0;
    {clock_enable, global_init_low} = 2'h3;
    avs_address = 4'h0;
    avs_byteenable = 4'hF;  // whole words only
    avs_writedata = 32'h0;
    level_in = 4'h0;
    err_count = 0;
    comparisons = 0;
    cyc(10);
    rstn <= 1'b1;
    cyc(5);
    // reset values and an unmapped hole
    bus(1'b0, `ELEM_CTRL_ADDR, 32'h0); check_bus(rd, {16'h0, `ELEM_CTRL_RST});
    bus(1'b0, `OUT_SEL_ADDR, 32'h0); check_bus(rd, {22'h0, `OUT_SEL_RST});
    bus(1'b0, 4'h1, 32'h0); check_bus(rd, 32'h0);
    // ordinary cases: configure, pulse the cell clock, moving data while high
    foreach (rows[i]) begin
      r = rows[i];
      bus(1'b1, `CELL_CTRL_ADDR, {24'h0, r[43:36]});
      bus(1'b1, `ELEM_CTRL_ADDR, {16'h0, r[35:20]});
      level_in <= r[19:16];
      clock_enable <= r[8];
      local_set_reset <= r[4];
      cyc(5); cell_clock <= 1'b1;
      cyc(5); level_in <= r[15:12];
      cyc(5); cell_clock <= 1'b0;
      cyc(5);
      check_cell({cell_out, storage_q}, {r[0], r[3:0], r[3:0]});
    end
    // crossed output routing and the status word of a corner cell
    bus(1'b1, `OUT_SEL_ADDR, 32'h01B);
    cyc(3); check_cell({cell_out, storage_q}, {5'h06, 4'h6});
    bus(1'b0, `STATUS_ADDR, 32'h0); check_bus(rd, 32'h36);
    // asynchronous set/reset forces with no clock and holds through one
    bus(1'b1, `CELL_CTRL_ADDR, 32'h10);
    bus(1'b1, `ELEM_CTRL_ADDR, 32'h00AF);
    bus(1'b0, `CELL_CTRL_ADDR, 32'h0); check_bus(rd, 32'h10);
    clock_enable <= 1'b1;
    local_set_reset <= 1'b1;
    // outputs still carry the crossed routing: o0..o3 show q3..q0
    cyc(5); check_cell({cell_out[3:0], storage_q, 1'b0}, {4'h5, 4'hA, 1'b0});
    cell_clock <= 1'b1;
    cyc(5); check_cell({cell_out[3:0], storage_q, 1'b0}, {4'h5, 4'hA, 1'b0});
    cell_clock <= 1'b0;
    local_set_reset <= 1'b0;
    // global init overrides, with a different set pattern
    bus(1'b1, `ELEM_CTRL_ADDR, 32'h005F);
    global_init_low <= 1'b0;
    cyc(5); check_cell({cell_out[3:0], storage_q, 1'b0}, {4'hA, 4'h5, 1'b0});
    global_init_low <= 1'b1;
    // second reset in mid-run
    cyc(3); rstn <= 1'b0;
    cyc(2); check_cell({cell_out, storage_q}, 9'h000);
    rstn <= 1'b1;
    cyc(5);
    bus(1'b0, `ELEM_CTRL_ADDR, 32'h0); check_bus(rd, {16'h0, `ELEM_CTRL_RST});
    // partial write: only the low byte lane lands
    avs_byteenable <= 4'h1;
    bus(1'b1, `OUT_SEL_ADDR, 32'h3FF);
    avs_byteenable <= 4'hF;
    bus(1'b0, `OUT_SEL_ADDR, 32'h0); check_bus(rd, 32'h0FF);
    final_report();
  end
endmodule
`default_nettype wire

// ### testbench/cell_storage_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "cell_storage_consts.vh"
module cell_storage_checker (
  input wire logic                 clk,
  input wire logic                 rstn,
  input wire logic [`ADDR_W-1:0]   avs_address,
  input wire logic                 avs_read,
  input wire logic                 avs_write,
  input wire logic [`BUS_W-1:0]    avs_writedata,
  input wire logic [`BE_W-1:0]     avs_byteenable,
  input wire logic [`BUS_W-1:0]    avs_readdata,
  input wire logic                 avs_waitrequest,
  input wire logic [`ELEM_N-1:0]   quarter_table,
  input wire logic [`ELEM_N-1:0]   direct_data_in,
  input wire logic [`ELEM_N-1:0]   side_pad_in,
  input wire logic [`ELEM_N-1:0]   vert_pad_in,
  input wire logic                 cell_clock,
  input wire logic                 clock_enable,
  input wire logic                 local_set_reset,
  input wire logic                 global_init_low,
  input wire logic [`ELEM_N-1:0]   storage_q,
  input wire logic [`OUT_N-1:0]    cell_out
);
  logic [`CC_W-1:0] cc_t;     // shadow of cell control, fed from the bus
  logic [`EC_W-1:0] ec_t;     // shadow of element control
  logic [`OS_W-1:0] os_t;     // shadow of output select
  logic [19:0]      prev_in;  // fabric inputs one edge ago
  logic [3:0]       quiet;    // edges with no input change and no write
  logic [4:0]       route;    // cell outputs expected from storage_q
  wire  [19:0] fab = {quarter_table, direct_data_in, side_pad_in, vert_pad_in,
                      cell_clock, clock_enable, local_set_reset, global_init_low};
  wire  [31:0] be_m = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                       {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire  [31:0] cc_w = ({25'h0, cc_t} & ~be_m) | (avs_writedata & be_m);
  wire  [31:0] ec_w = ({16'h0, ec_t} & ~be_m) | (avs_writedata & be_m);
  wire  [31:0] os_w = ({22'h0, os_t} & ~be_m) | (avs_writedata & be_m);
  wire         wr_ok = avs_write && !avs_waitrequest;
  wire         ce_on = clock_enable ^ cc_t[`CC_CE_INV];
  wire         sr_on = local_set_reset ^ cc_t[`CC_SR_INV];
  wire  [1:0]  mode  = cc_t[`CC_MODE_HI:`CC_MODE_LO];
  // shadows follow writes at the answer edge; quiet restarts on any input change or write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cc_t    <= `CELL_CTRL_RST;
      ec_t    <= `ELEM_CTRL_RST;
      os_t    <= `OUT_SEL_RST;
      prev_in <= '0;
      quiet   <= '0;
    end else begin
      if (wr_ok && avs_address == `CELL_CTRL_ADDR) cc_t <= cc_w[`CC_W-1:0];
      if (wr_ok && avs_address == `ELEM_CTRL_ADDR) ec_t <= ec_w[`EC_W-1:0];
      if (wr_ok && avs_address == `OUT_SEL_ADDR) os_t <= os_w[`OS_W-1:0];
      prev_in <= fab;
      if (fab != prev_in || avs_write) quiet <= '0;
      else if (quiet != 4'hF) quiet <= quiet + 4'h1;
    end
  end
  // routing of element states onto the five outputs
  always_comb begin
    for (int j = 0; j < 5; j++) route[j] = storage_q[os_t[2*j +: 2]];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer one cycle after a request");
  chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_ctrl_readback: assert property (avs_read && avs_waitrequest && avs_address == `CELL_CTRL_ADDR
    |=> avs_readdata == {25'h0, cc_t}) else $error("cell control reads back wrong");
  chk_out_route: assert property (os_t == $past(os_t) |-> cell_out == route)
    else $error("cell output not routed from selected element");
  chk_quiet_stable: assert property (quiet >= 4'h6 |-> $stable(storage_q))
    else $error("element state moved with all inputs still");
  chk_enable_hold: assert property ((mode != `MODE_ASYNC && !cc_t[`CC_PRIO] && ec_t[3:0] == 4'hF
    && !ce_on && global_init_low)[*8] |-> $stable(storage_q)) else $error("flip-flop moved while disabled");
  chk_async_force: assert property ((mode == `MODE_ASYNC && sr_on && global_init_low
    && $stable({cc_t, ec_t}))[*5] |-> storage_q == ec_t[7:4]) else $error("async set/reset not forcing");
  chk_global_force: assert property ((!global_init_low && $stable(ec_t))[*5]
    |-> storage_q == ec_t[7:4]) else $error("global init not forcing");
  cover property (!global_init_low[*5]);
  cover property (mode == `MODE_FES && sr_on);
  cover property (avs_read && !avs_waitrequest);
endmodule
bind cell_storage_elements cell_storage_checker u_cell_storage_checker (.clk, .rstn, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .quarter_table, .direct_data_in, .side_pad_in, .vert_pad_in, .cell_clock, .clock_enable,
  .local_set_reset, .global_init_low, .storage_q, .cell_out);
`default_nettype wire

// ### testbench/fabric_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "cell_storage_consts.vh"
// tables and routing ahead of the cell: one level fans out, each source distinct
module fabric_model (
  input  wire logic [3:0]         level_in,
  output wire logic [`ELEM_N-1:0] quarter_table,
  output wire logic [`ELEM_N-1:0] direct_data_in,
  output wire logic [`ELEM_N-1:0] side_pad_in,
  output wire logic [`ELEM_N-1:0] vert_pad_in
);
  assign quarter_table  = level_in ^ 4'h5;                 // fixed table function
  assign direct_data_in = level_in;                        // straight route
  assign side_pad_in    = {level_in[1:0], level_in[3:2]};  // swapped halves
  assign vert_pad_in    = ~level_in;                       // inverted pad path
endmodule
`default_nettype wire
